// >>> shared/asdma_defs.vh
/*
  Constants of the four-channel audio sample DMA block: register
  indices, field positions and reset values.
  Assumes inclusion by bare name from the design files.
*/
`ifndef ASDMA_DEFS_VH
`define ASDMA_DEFS_VH

// Register index width and channel register layout (index = ch*8 + sub)
`define ASDMA_ADDR_W          6
`define ASDMA_SUB_ADDR_HIGH   3'h0
`define ASDMA_SUB_ADDR_LOW    3'h1
`define ASDMA_SUB_WORD_COUNT  3'h2
`define ASDMA_SUB_VOLUME      3'h3
`define ASDMA_SUB_PERIOD      3'h4

// Global registers
`define ASDMA_REG_CONTROL     6'h20
`define ASDMA_REG_STATUS      6'h21

// Control register fields
`define ASDMA_CTL_MASTER_BIT  9
`define ASDMA_CTL_CHAN_LSB    0

// Field widths and the full-scale volume code
`define ASDMA_ADDR_HIGH_W     3
`define ASDMA_ADDR_LOW_W      15
`define ASDMA_VOL_W           7
`define ASDMA_VOL_FULL        7'h40

// Reset values
`define ASDMA_RST_ADDR_HIGH   3'h0
`define ASDMA_RST_ADDR_LOW    15'h0000
`define ASDMA_RST_WORD_COUNT  16'h0000
`define ASDMA_RST_VOLUME      7'h00
`define ASDMA_RST_PERIOD      16'h007c
`define ASDMA_RST_CONTROL     16'h0000

`endif

// >>> hw/asdma_fifo.v
/*
  Small synchronous FIFO with valid/ready on both sides and a flush.
  Assumes one clock; the source honours in_ready_o, the sink out_valid_o.
*/
`timescale 1ns/10ps
module asdma_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             reset_n_i,
  // Flush
  input  wire             flush_i,
  // Fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;

  wire push = in_valid_i & in_ready_o;
  wire pop  = out_valid_o & out_ready_i;

  // Honest flags straight from the occupancy count
  assign in_ready_o  = (count_reg != DEPTH[AW:0]);
  assign out_valid_o = (count_reg != {(AW+1){1'b0}});
  assign out_data_o  = mem_reg[rd_ptr_reg];

  // Storage, no reset needed on data
  always @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers wrap at DEPTH, which may be any size up to 2**AW
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else if (flush_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                    : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                    : rd_ptr_reg + 1'b1;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule // asdma_fifo

// >>> hw/asdma_top.v
/*
  Four-channel audio sample DMA engine: register file, word fetcher
  with per-line slots, per-channel word FIFO, rate counters, volume
  scaling and stereo mixing.
  Assumes a memory port that returns read data in order, one request
  outstanding, and a one-cycle line_start_i pulse per scan line.
*/
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`include "asdma_defs.vh"
module asdma_top #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW    = 2
) (
  // Clock and reset
  input  wire                     clk_i,
  input  wire                     reset_n_i,
  // Register port
  input  wire [`ASDMA_ADDR_W-1:0] reg_addr_i,
  input  wire [31:0]              reg_wdata_i,
  input  wire                     reg_wr_i,
  input  wire                     reg_wlong_i,
  input  wire                     reg_rd_i,
  output reg  [15:0]              reg_rdata_o,
  // Slot timing
  input  wire                     line_start_i,
  // Memory read port
  output wire                     mem_req_o,
  output reg  [17:0]              mem_word_addr_o,
  input  wire                     mem_ready_i,
  input  wire                     mem_rvalid_i,
  input  wire [15:0]              mem_rdata_i,
  // Converter and stereo outputs
  output reg  [31:0]              chan_sample_o,
  output reg  [16:0]              left_o,
  output reg  [16:0]              right_o
);

  // Fetch engine states
  localparam ST_IDLE = 2'h0;
  localparam ST_REQ  = 2'h1;
  localparam ST_WAIT = 2'h2;

  // Register file
  // Write-only from software: channel registers read back as zero, so
  // their contents show only through fetch addresses and playback.
  // Volume keeps seven bits so that full scale, code 64, fits.
  reg [`ASDMA_ADDR_HIGH_W-1:0] addr_high_reg [0:3];
  reg [`ASDMA_ADDR_LOW_W-1:0]  addr_low_reg  [0:3];
  reg [15:0]                   word_count_reg [0:3];
  reg [`ASDMA_VOL_W-1:0]       volume_reg    [0:3];
  reg [15:0]                   period_reg    [0:3];
  reg                          master_transfer_enable_reg;
  reg [3:0]                    channel_transfer_enable_reg;

  // Fetch state
  // Live pointer and count kept apart from the stored start, so a
  // restart never disturbs what software wrote
  reg [17:0]                   ptr_reg       [0:3];
  reg [15:0]                   remain_reg    [0:3];
  reg [3:0]                    slot_used_reg;
  reg [3:0]                    run_reg;
  reg [1:0]                    state_reg;
  reg [1:0]                    sel_reg;

  // Playback state
  // Low byte waits here while the high byte plays; the FIFO is popped
  // in the cycle the high byte loads, as the low byte is captured
  reg [15:0]                   cnt_reg       [0:3];
  reg [7:0]                    sample_reg    [0:3];
  reg [7:0]                    low_byte_reg  [0:3];
  reg [3:0]                    half_reg;

  // FIFO connections
  // Four words of slack let fetches run lines ahead of playback
  wire [3:0]                   fifo_in_valid;
  wire [3:0]                   fifo_in_ready;
  wire [3:0]                   fifo_out_valid;
  wire [3:0]                   fifo_out_ready;
  wire [15:0]                  fifo_out_data [0:3];
  wire [15:0]                  scaled        [0:3];

  // Decode of the register index
  // Index bit 5 splits channel registers from the global ones
  wire       chan_access = ~reg_addr_i[5];
  wire [1:0] acc_ch      = reg_addr_i[4:3];
  wire [2:0] acc_sub     = reg_addr_i[2:0];

  // Channel may fetch only with both enables
  // Dropping either also flushes the channel's words and silences it;
  // enabling again restarts from the stored start
  wire [3:0] chan_active = channel_transfer_enable_reg &
                           {4{master_transfer_enable_reg}};

  // Channel is eligible for a slot if unused this line and buffer has room
  wire [3:0] eligible = chan_active & ~slot_used_reg & fifo_in_ready;

  integer i;

  // Register writes; a long write at the high index also fills the low
  // Plain writes use the low sixteen data bits only. Bit 0 of the low
  // start half is dropped, as the start is always word aligned.
  // Unmapped indices are ignored rather than aliased.
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (i = 0; i < 4; i = i + 1) begin
        addr_high_reg[i]  <= `ASDMA_RST_ADDR_HIGH;
        addr_low_reg[i]   <= `ASDMA_RST_ADDR_LOW;
        word_count_reg[i] <= `ASDMA_RST_WORD_COUNT;
        volume_reg[i]     <= `ASDMA_RST_VOLUME;
        period_reg[i]     <= `ASDMA_RST_PERIOD;
      end
      master_transfer_enable_reg  <= 1'b0;
      channel_transfer_enable_reg <= 4'h0;
    end else if (reg_wr_i) begin
      if (chan_access) begin
        case (acc_sub)
          `ASDMA_SUB_ADDR_HIGH: begin
            if (reg_wlong_i) begin
              addr_high_reg[acc_ch] <= reg_wdata_i[18:16];
              addr_low_reg[acc_ch]  <= reg_wdata_i[15:1];
            end else begin
              addr_high_reg[acc_ch] <= reg_wdata_i[2:0];
            end
          end
          `ASDMA_SUB_ADDR_LOW:
            addr_low_reg[acc_ch] <= reg_wdata_i[15:1];
          `ASDMA_SUB_WORD_COUNT:
            word_count_reg[acc_ch] <= reg_wdata_i[15:0];
          `ASDMA_SUB_VOLUME:
            volume_reg[acc_ch] <= reg_wdata_i[6:0];
          `ASDMA_SUB_PERIOD:
            period_reg[acc_ch] <= reg_wdata_i[15:0];
          default: ;
        endcase
      end else if (reg_addr_i == `ASDMA_REG_CONTROL) begin
        master_transfer_enable_reg  <= reg_wdata_i[`ASDMA_CTL_MASTER_BIT];
        channel_transfer_enable_reg <= reg_wdata_i[`ASDMA_CTL_CHAN_LSB +: 4];
      end
    end
  end

  // Read data one cycle after the strobe; unmapped indices read zero
  // Zero outside the read cycle lets slaves be ORed together; the cost
  // is that nothing of a read stays visible afterwards
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      if (reg_addr_i == `ASDMA_REG_CONTROL) begin
        reg_rdata_o <= {6'h00, master_transfer_enable_reg, 5'h00,
                        channel_transfer_enable_reg};
      end else if (reg_addr_i == `ASDMA_REG_STATUS) begin
        reg_rdata_o <= {half_reg, fifo_out_valid, slot_used_reg, run_reg};
      end else begin
        reg_rdata_o <= 16'h0000;
      end
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  // One fetch outstanding; requests hold until the memory accepts
  // Combinational from the state, so the request drops in the cycle
  // after acceptance and never issues twice
  assign mem_req_o = (state_reg == ST_REQ);

  // Fetch engine: round-robin over channels, slot marks cleared per line
  // A channel is served when it has its slot, room and a running pass;
  // otherwise the turn passes on, so one stalled channel blocks nobody
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg       <= ST_IDLE;
      sel_reg         <= 2'h0;
      slot_used_reg   <= 4'h0;
      run_reg         <= 4'h0;
      mem_word_addr_o <= 18'h00000;
      for (i = 0; i < 4; i = i + 1) begin
        ptr_reg[i]    <= 18'h00000;
        remain_reg[i] <= 16'h0000;
      end
    end else begin
      // Start of a pass loads pointer and count from the stored values
      for (i = 0; i < 4; i = i + 1) begin
        run_reg[i] <= chan_active[i];
        if (chan_active[i] & ~run_reg[i]) begin
          ptr_reg[i]    <= {addr_high_reg[i], addr_low_reg[i]};
          remain_reg[i] <= word_count_reg[i];
        end
      end
      if (line_start_i) begin
        slot_used_reg <= 4'h0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (eligible[sel_reg] & run_reg[sel_reg] & ~line_start_i) begin
            mem_word_addr_o <= ptr_reg[sel_reg];
            state_reg       <= ST_REQ;
          end else begin
            sel_reg <= sel_reg + 2'h1;
          end
        end
        ST_REQ: begin
          if (mem_ready_i) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (mem_rvalid_i) begin
            state_reg <= ST_IDLE;
            sel_reg   <= sel_reg + 2'h1;
            // Set beats the line pulse: a word landing then counts
            // against the new line, never letting a second one in
            slot_used_reg[sel_reg] <= 1'b1;
            if (remain_reg[sel_reg] == 16'h0001) begin
              // Last word: reload from start, stored values untouched
              ptr_reg[sel_reg] <= {addr_high_reg[sel_reg],
                                   addr_low_reg[sel_reg]};
              remain_reg[sel_reg] <= word_count_reg[sel_reg];
            end else begin
              ptr_reg[sel_reg]    <= ptr_reg[sel_reg] + 18'h00001;
              remain_reg[sel_reg] <= remain_reg[sel_reg] - 16'h0001;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Per-channel word buffers; a full buffer stalls that channel's fetch
  // Flushing on disable keeps stale words of an old buffer from playing
  // after a restart; a word in flight at that moment is dropped at the
  // FIFO input
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_chan
      assign fifo_in_valid[g] = (state_reg == ST_WAIT) & mem_rvalid_i &
                                (sel_reg == g) & chan_active[g];
      assign fifo_out_ready[g] = run_reg[g] & (cnt_reg[g] == 16'h0000) &
                                 ~half_reg[g];

      asdma_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
      ) u_fifo (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .flush_i     (~chan_active[g]),
        .in_valid_i  (fifo_in_valid[g]),
        .in_ready_o  (fifo_in_ready[g]),
        .in_data_i   (mem_rdata_i),
        .out_valid_o (fifo_out_valid[g]),
        .out_ready_i (fifo_out_ready[g]),
        .out_data_o  (fifo_out_data[g])
      );

      // Codes above full scale clamp to full scale
      wire [`ASDMA_VOL_W-1:0] vol_eff =
        (volume_reg[g] > `ASDMA_VOL_FULL) ? `ASDMA_VOL_FULL
                                          : volume_reg[g];
      // Signed byte times unsigned volume, linear in the code
      assign scaled[g] = $signed({{8{sample_reg[g][7]}}, sample_reg[g]}) *
                         $signed({9'h000, vol_eff});
    end
  endgenerate

  // Rate counters and byte sequencing per channel
  // Reload with period minus one gives a sample every period cycles;
  // a period of zero wraps and acts as 65536. Too short a period
  // starves the FIFO, and the channel then repeats its last sample
  // rather than stalling the count.
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      half_reg <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        cnt_reg[i]      <= 16'h0000;
        sample_reg[i]   <= 8'h00;
        low_byte_reg[i] <= 8'h00;
      end
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (~run_reg[i]) begin
          // Idle channel sits at mid-scale, counter primed
          cnt_reg[i]    <= 16'h0000;
          sample_reg[i] <= 8'h00;
          half_reg[i]   <= 1'b0;
        end else if (cnt_reg[i] == 16'h0000) begin
          cnt_reg[i] <= period_reg[i] - 16'h0001;
          if (half_reg[i]) begin
            sample_reg[i] <= low_byte_reg[i];
            half_reg[i]   <= 1'b0;
          end else if (fifo_out_valid[i]) begin
            sample_reg[i]   <= fifo_out_data[i][15:8];
            low_byte_reg[i] <= fifo_out_data[i][7:0];
            half_reg[i]     <= 1'b1;
          end
          // No word yet: the previous sample stays on the converter
        end else begin
          cnt_reg[i] <= cnt_reg[i] - 16'h0001;
        end
      end
    end
  end

  // Converter bytes and stereo mixing, registered
  // Outputs lag the sample registers by one cycle; the widened sum of
  // two scaled bytes cannot overflow seventeen bits
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chan_sample_o <= 32'h00000000;
      left_o        <= 17'h00000;
      right_o       <= 17'h00000;
    end else begin
      chan_sample_o <= {sample_reg[3], sample_reg[2],
                        sample_reg[1], sample_reg[0]};
      left_o  <= {scaled[1][15], scaled[1]} +
                 {scaled[2][15], scaled[2]};
      right_o <= {scaled[0][15], scaled[0]} +
                 {scaled[3][15], scaled[3]};
    end
  end

endmodule // asdma_top

// >>> verif/asdma_checker.sv
/* Port checker for the audio sample DMA top: register read timing,
   fetch handshake, slot budget and mixing signs.
   Assumes one clock domain and binding to asdma_top. */
`timescale 1ns/10ps
`include "asdma_defs.vh"
module asdma_checker (
  // Clock and reset
  input wire        clk_i,
  input wire        reset_n_i,
  // Register port
  input wire [5:0]  reg_addr_i,
  input wire        reg_rd_i,
  input wire [15:0] reg_rdata_o,
  // Slot timing and memory port
  input wire        line_start_i,
  input wire        mem_req_o,
  input wire [17:0] mem_word_addr_o,
  input wire        mem_ready_i,
  input wire        mem_rvalid_i,
  // Samples and stereo outputs
  input wire [31:0] chan_sample_o,
  input wire [16:0] left_o,
  input wire [16:0] right_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  reg       wait_reg;
  reg [2:0] fetch_cnt_reg;
  // Outstanding fetch and words per line; counter saturates, never wraps
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_reg <= 1'b0;
      fetch_cnt_reg <= 3'h0;
    end else begin
      if (mem_req_o && mem_ready_i) wait_reg <= 1'b1;
      else if (mem_rvalid_i) wait_reg <= 1'b0;
      if (line_start_i) fetch_cnt_reg <= {2'h0, mem_rvalid_i};
      else if (mem_rvalid_i && wait_reg && fetch_cnt_reg != 3'h7)
        fetch_cnt_reg <= fetch_cnt_reg + 3'h1;
    end
  end
  rdata_idle_a: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside read cycle");
  rdata_wo_a: assert property (
    $past(reg_rd_i) && $past(reg_addr_i) != `ASDMA_REG_CONTROL &&
    $past(reg_addr_i) != `ASDMA_REG_STATUS |-> reg_rdata_o == 16'h0000)
    else $error("write-only or unmapped index read nonzero");
  req_hold_a: assert property (
    mem_req_o && !mem_ready_i |=> mem_req_o && $stable(mem_word_addr_o))
    else $error("fetch request dropped or moved");
  one_out_a: assert property (
    mem_req_o && mem_ready_i |=> !mem_req_o)
    else $error("second fetch while one outstanding");
  wait_quiet_a: assert property (
    wait_reg |-> !mem_req_o && $stable(mem_word_addr_o))
    else $error("fetch port moved while waiting");
  idle_gap_a: assert property (
    wait_reg && mem_rvalid_i |=> !mem_req_o)
    else $error("no idle cycle after fetch data");
  slot_budget_a: assert property (
    fetch_cnt_reg <= 3'h4)
    else $error("more than four words in one line");
  mix_zero_a: assert property (
    (chan_sample_o == 32'h0)[*2] |-> left_o == 17'h0 && right_o == 17'h0)
    else $error("silent channels give output");
  left_sign_a: assert property (
    (!chan_sample_o[15] && !chan_sample_o[23])[*2] |-> !left_o[16])
    else $error("left sign wrong");
  right_sign_a: assert property (
    (chan_sample_o[7] && chan_sample_o[31])[*2] |->
    right_o[16] || right_o == 17'h0)
    else $error("right sign wrong");
endmodule // asdma_checker
bind asdma_top asdma_checker u_checker (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .line_start_i(line_start_i), .mem_req_o(mem_req_o),
  .mem_word_addr_o(mem_word_addr_o), .mem_ready_i(mem_ready_i),
  .mem_rvalid_i(mem_rvalid_i), .chan_sample_o(chan_sample_o),
  .left_o(left_o), .right_o(right_o));

// >>> verif/asdma_mem_model.sv
/* Shared sample memory seen through the fetch port, with random stalls.
   Assumes one request at a time; word content follows its address. */
`timescale 1ns/10ps
module asdma_mem_model (
  // Clock and reset
  input  wire        clk_i,
  input  wire        reset_n_i,
  // Fetch port
  input  wire        mem_req_i,
  input  wire [17:0] addr_i,
  output reg         mem_ready_o,
  output reg         mem_rvalid_o,
  output reg  [15:0] mem_rdata_o
);
  integer    seed = 32'hbe9d;
  integer    rnd;
  reg        busy_reg;
  reg [1:0]  wait_reg;
  reg [17:0] addr_reg;
  // Accept after a random stall, answer after 1 to 4 idle cycles
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mem_ready_o <= 1'b0;
      mem_rvalid_o <= 1'b0;
      mem_rdata_o <= 16'h0000;
      busy_reg <= 1'b0;
      wait_reg <= 2'h0;
      addr_reg <= 18'h0;
    end else begin
      rnd = $random(seed);
      mem_ready_o <= 1'b0;
      mem_rvalid_o <= 1'b0;
      // Data lines released: never leave the last word standing
      if (mem_rvalid_o) mem_rdata_o <= ~mem_rdata_o;
      if (busy_reg) begin
        if (wait_reg == 2'h0) begin
          mem_rvalid_o <= 1'b1;
          mem_rdata_o <= {addr_reg[6:0], 1'b0, ~addr_reg[6],
                          addr_reg[5:0], 1'b1};
          busy_reg <= 1'b0;
        end else wait_reg <= wait_reg - 2'h1;
      end else if (mem_ready_o && mem_req_i) begin
        busy_reg <= 1'b1;
        addr_reg <= addr_i;
        wait_reg <= rnd[1:0];
      end else if (mem_req_i && rnd[3:2] != 2'h0) mem_ready_o <= 1'b1;
    end
  end
endmodule // asdma_mem_model

// >>> verif/tb.sv
/* Self-checking bench of the audio sample DMA top with a memory model.
   Assumes the register layout of asdma_defs.vh and a line every LINE. */
`timescale 1ns/10ps
`include "asdma_defs.vh"
module tb;
  localparam int LINE = 40;
  reg         clk_i = 1'b0;
  reg         reset_n_i = 1'b0;
  reg  [5:0]  reg_addr_i = 6'h0;
  reg  [31:0] reg_wdata_i = 32'h0;
  reg         reg_wr_i = 1'b0;
  reg         reg_wlong_i = 1'b0;
  reg         reg_rd_i = 1'b0;
  reg         line_start_i = 1'b0;
  wire        mem_req_o, mem_ready_i, mem_rvalid_i;
  wire [17:0] mem_word_addr_o;
  wire [15:0] mem_rdata_i, reg_rdata_o;
  wire [31:0] chan_sample_o;
  wire [16:0] left_o, right_o;
  integer     seed = 32'hbe9d;
  integer     fails = 0, samples_checked = 0, cyc = 0, nreq = 0;
  integer     i, n0, ch;
  reg  [17:0] addr_q[$];
  reg  [7:0]  smp_q[$];
  reg  [7:0]  last_smp = 8'h0;
  reg  [6:0]  vol[4];
  reg  [31:0] r;
  reg  [17:0] st;
  reg  [15:0] w;
  always #5 clk_i = ~clk_i;
  // Line pulses, fetch log, channel 0 sample log and run limit
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    line_start_i <= (cyc % LINE == LINE - 1);
    if (mem_req_o && mem_ready_i) begin
      nreq <= nreq + 1;
      addr_q.push_back(mem_word_addr_o);
    end
    if (chan_sample_o[7:0] !== last_smp) begin
      smp_q.push_back(chan_sample_o[7:0]);
      last_smp <= chan_sample_o[7:0];
    end
    if (cyc == 8000) begin
      fails = fails + 1;
      print_verdict();
    end
  end
  asdma_top DUT (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_wlong_i(reg_wlong_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .line_start_i(line_start_i),
    .mem_req_o(mem_req_o), .mem_word_addr_o(mem_word_addr_o),
    .mem_ready_i(mem_ready_i), .mem_rvalid_i(mem_rvalid_i),
    .mem_rdata_i(mem_rdata_i), .chan_sample_o(chan_sample_o),
    .left_o(left_o), .right_o(right_o));
  asdma_mem_model u_mem (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .mem_req_i(mem_req_o), .addr_i(mem_word_addr_o),
    .mem_ready_o(mem_ready_i), .mem_rvalid_o(mem_rvalid_i),
    .mem_rdata_o(mem_rdata_i));
  function automatic [15:0] word(input [17:0] a);
    word = {a[6:0], 1'b0, ~a[6], a[5:0], 1'b1};
  endfunction
  // Codes above full scale clamp to full scale
  function automatic [6:0] veff(input [6:0] v);
    veff = (v > 7'h40) ? 7'h40 : v;
  endfunction
  function automatic [16:0] mix(input [7:0] a, input [6:0] va,
                                input [7:0] b, input [6:0] vb);
    mix = $signed(a) * $signed({1'b0, va}) + $signed(b) * $signed({1'b0, vb});
  endfunction
  task automatic compare(input string what, input [31:0] exp, got);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input [5:0] a, input [31:0] d, input lng);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    reg_wlong_i <= lng;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    reg_wlong_i <= 1'b0;
  endtask
  task automatic rd_chk(input [5:0] a, input [15:0] exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 compare("read data", exp, reg_rdata_o);
  endtask
  // Long write of the start, then count, volume and period
  task automatic setup(input [1:0] c, input [17:0] s, input [15:0] n,
                       input [15:0] v, input [15:0] p);
    wr({1'b0, c, `ASDMA_SUB_ADDR_HIGH}, {13'h0, s, 1'b0}, 1'b1);
    wr({1'b0, c, `ASDMA_SUB_WORD_COUNT}, {16'h0, n}, 1'b0);
    wr({1'b0, c, `ASDMA_SUB_VOLUME}, {16'h0, v}, 1'b0);
    wr({1'b0, c, `ASDMA_SUB_PERIOD}, {16'h0, p}, 1'b0);
    vol[c] = veff(v[6:0]);
  endtask
  // Waits for a steady sample set, then checks both mixes
  task automatic check_mix;
    reg [31:0] s;
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_i);
      #1 s = chan_sample_o;
      repeat (2) @(posedge clk_i);
      #1 if (chan_sample_o === s) break;
    end
    compare("left", {15'h0, mix(s[15:8], vol[1], s[23:16], vol[2])}, left_o);
    compare("right", {15'h0, mix(s[7:0], vol[0], s[31:24], vol[3])}, right_o);
  endtask
  task automatic print_verdict;
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    for (i = 0; i < 4; i++) vol[i] = 7'h0;
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd_chk(`ASDMA_REG_CONTROL, 16'h0000);
    rd_chk(`ASDMA_REG_STATUS, 16'h0000);
    rd_chk(6'h3f, 16'h0000);
    r = $random(seed);
    st = {1'b0, r[16:1], 1'b1};
    setup(2'h0, st, 16'h3, 16'h0040, 16'h001e);
    rd_chk({3'h0, `ASDMA_SUB_VOLUME}, 16'h0000);
    // Channels enabled without the master, then master alone
    wr(`ASDMA_REG_CONTROL, 32'h000f, 1'b0);
    repeat (200) @(posedge clk_i);
    compare("fetches", 32'h0, nreq);
    wr(`ASDMA_REG_CONTROL, 32'h0200, 1'b0);
    repeat (200) @(posedge clk_i);
    compare("fetches", 32'h0, nreq);
    wr(`ASDMA_REG_CONTROL, 32'h0201, 1'b0);
    rd_chk(`ASDMA_REG_CONTROL, 16'h0201);
    repeat (500) @(posedge clk_i);
    for (i = 0; i < 5; i++)
      compare("fetch addr", st + i % 3, addr_q[i]);
    for (i = 0; i < 10; i++) begin
      w = word(st + (i / 2) % 3);
      compare("sample", (i % 2) ? w[7:0] : w[15:8], smp_q[i]);
    end
    // Volume codes at the edges and past full scale
    for (int k = 0; k < 4; k++) begin
      w = $random(seed);
      w[6:0] = (k == 3) ? 7'h55 : 7'h20 * k;
      wr({3'h0, `ASDMA_SUB_VOLUME}, {16'h0, w}, 1'b0);
      vol[0] = veff(w[6:0]);
      check_mix();
    end
    // All four channels at once
    for (ch = 1; ch < 4; ch++) begin
      r = $random(seed);
      setup(ch[1:0], {1'b0, r[16:0]}, {14'h0, r[30:29]} + 16'h1,
            r[15:0], 16'h001e + ch[15:0]);
    end
    wr(`ASDMA_REG_CONTROL, 32'h020f, 1'b0);
    repeat (300) @(posedge clk_i);
    repeat (4) check_mix();
    // Period far below the slot rate: samples must repeat, not stall
    wr({3'h0, `ASDMA_SUB_PERIOD}, 32'h4, 1'b0);
    n0 = smp_q.size();
    repeat (400) @(posedge clk_i);
    // At most two samples per line slot, plus what the FIFO held
    n0 = smp_q.size() - n0;
    compare("changes", 32'h1, 32'(n0 inside {[4:2*(400/LINE)+12]}));
    // Start loaded as separate halves
    wr(`ASDMA_REG_CONTROL, 32'h0200, 1'b0);
    r = $random(seed);
    wr({3'h0, `ASDMA_SUB_ADDR_HIGH}, {29'h0, r[17:15]}, 1'b0);
    wr({3'h0, `ASDMA_SUB_ADDR_LOW}, {16'h0, r[14:0], 1'b0}, 1'b0);
    repeat (20) @(posedge clk_i);
    n0 = addr_q.size();
    wr(`ASDMA_REG_CONTROL, 32'h0201, 1'b0);
    repeat (100) @(posedge clk_i);
    compare("fetch addr", {14'h0, r[17:0]}, addr_q[n0]);
    print_verdict();
  end
endmodule // tb
